/* src/psop_pkg.sv */
// Shared constants, limits and control carrier for the parallel sum-of-products datapath
//
// What this block does
// - Operand width is 3, 4, 5, 6, 7, 8 or 16 bits, default 8.
// - One to twenty-four parallel multipliers, default 8, all products summed together.
// - Operands are signed by default; A and B each have an unsigned option.
// - Optional input registers add one cycle; separate A/B enables, shared reset.
// - Hide options tie input or pipeline enables and resets to one.
// - With accumulation on, output is the running total of every cycle's sum.
// - Accumulation gives a load input; asserting it restarts the total from that sum.
// - Zero, one or two pipeline stages, default 0, each adds one cycle.
// - Result output width is 3 to 48 bits, default 48.
// - Results wider than the output drop high bits, with no overflow flag.
// - Load is delayed to match operand latency; it takes the sum, ignoring history.
// - Input and pipeline resets are synchronous and active low.
package psop_pkg;

    // ------------------------------------------------------------------
    // Limits and defaults
    // ------------------------------------------------------------------
    localparam int PSOP_IN_WIDTH_DEF = 8;
    localparam int PSOP_NMULT_DEF    = 8;
    localparam int PSOP_NMULT_MIN    = 1;
    localparam int PSOP_NMULT_MAX    = 24;
    localparam int PSOP_OUT_DEF      = 48;
    localparam int PSOP_OUT_MIN      = 3;
    localparam int PSOP_OUT_MAX      = 48;
    localparam int PSOP_PIPE_DEF     = 0;
    localparam int PSOP_PIPE_MAX     = 2;
    localparam int PSOP_IN_REG_LAT   = 1;
    localparam int PSOP_OUT_REG_LAT  = 1;
    localparam bit PSOP_RST_VAL      = 1'b0;

    // ------------------------------------------------------------------
    // Width legality and multiplier ceiling per width
    // ------------------------------------------------------------------
    function automatic int psop_max_mult(input int width);
        case (width)
            3:       psop_max_mult = 24;
            4:       psop_max_mult = 16;
            5, 6:    psop_max_mult = 12;
            7:       psop_max_mult = 10;
            8:       psop_max_mult = 8;
            16:      psop_max_mult = 4;
            default: psop_max_mult = 0;
        endcase
    endfunction : psop_max_mult

    // ------------------------------------------------------------------
    // Control carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic a_ce;
        logic b_ce;
        logic in_rstn;
        logic pipe_ce;
        logic pipe_rstn;
        logic load;
    } psop_ctrl_t;

endpackage : psop_pkg

/* src/psop_lane.sv */
// One multiplier lane: signed/unsigned product extended or cut to the output width
`timescale 1ns/1ps
module psop_lane
    import psop_pkg::*;
#(
    parameter int IN_WIDTH   = PSOP_IN_WIDTH_DEF,
    parameter int OUT_WIDTH  = PSOP_OUT_DEF,
    parameter bit A_UNSIGNED = 1'b0,
    parameter bit B_UNSIGNED = 1'b0
) (
    input  wire logic [IN_WIDTH-1:0]  i_a,
    input  wire logic [IN_WIDTH-1:0]  i_b,
    output logic      [OUT_WIDTH-1:0] o_prod
);
    localparam int PW = 2 * IN_WIDTH + 2;

    logic signed [IN_WIDTH:0] a_ext;
    logic signed [IN_WIDTH:0] b_ext;
    logic signed [PW-1:0]     prod;

    // unsigned option clears the added sign bit
    assign a_ext = {(A_UNSIGNED ? 1'b0 : i_a[IN_WIDTH-1]), i_a};
    assign b_ext = {(B_UNSIGNED ? 1'b0 : i_b[IN_WIDTH-1]), i_b};
    assign prod  = PW'(a_ext) * PW'(b_ext);

    // sign bit of the widened product is zero when both sides unsigned
    generate
        if (OUT_WIDTH > PW) begin : g_ext
            assign o_prod = {{(OUT_WIDTH - PW){prod[PW-1]}}, prod};
        end else begin : g_cut
            assign o_prod = prod[OUT_WIDTH-1:0];
        end
    endgenerate

endmodule : psop_lane

/* src/psop_top.sv */
// Parallel sum-of-products datapath with optional input registers, pipeline and accumulator
`timescale 1ns/1ps
module psop_top
    import psop_pkg::*;
#(
    parameter int IN_WIDTH       = PSOP_IN_WIDTH_DEF,
    parameter int NUM_MULT       = PSOP_NMULT_DEF,
    parameter int OUT_WIDTH      = PSOP_OUT_DEF,
    parameter bit A_UNSIGNED     = 1'b0,
    parameter bit B_UNSIGNED     = 1'b0,
    parameter bit INPUT_REGS     = 1'b0,
    parameter bit HIDE_IN_CTRL   = 1'b0,
    parameter int PIPE_STAGES    = PSOP_PIPE_DEF,
    parameter bit HIDE_PIPE_CTRL = 1'b0,
    parameter bit ACCUM_EN       = 1'b0
) (
    input  wire logic                         i_core_clk,
    input  wire logic                         i_sys_rst,
    input  wire logic [IN_WIDTH*NUM_MULT-1:0] i_din_a,
    input  wire logic [IN_WIDTH*NUM_MULT-1:0] i_din_b,
    input  wire psop_ctrl_t                   i_ctrl,
    output logic      [OUT_WIDTH-1:0]         o_dout
);
    typedef logic [OUT_WIDTH-1:0] psop_word_t;
    localparam int DW = IN_WIDTH * NUM_MULT;
    // Stages allocated even when unused so the arrays never have zero size
    localparam int PD = (PIPE_STAGES > 0) ? PIPE_STAGES : 1;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_sys_rst);

    // ------------------------------------------------------------------
    // Configuration checks
    // ------------------------------------------------------------------
    // legal operand widths only
    AST_CFG_WIDTH: assert property (psop_max_mult(IN_WIDTH) > 0)
        else $error("operand width not one of 3..8 or 16");
    // count bounded by the width table
    AST_CFG_COUNT: assert property (NUM_MULT >= PSOP_NMULT_MIN && NUM_MULT <= PSOP_NMULT_MAX
                                    && NUM_MULT <= psop_max_mult(IN_WIDTH))
        else $error("multiplier count outside the limit for this width");
    AST_CFG_OUTW: assert property (OUT_WIDTH >= PSOP_OUT_MIN && OUT_WIDTH <= PSOP_OUT_MAX)
        else $error("output width outside 3 to 48");
    AST_CFG_PIPE: assert property (PIPE_STAGES >= 0 && PIPE_STAGES <= PSOP_PIPE_MAX)
        else $error("pipeline stage count outside 0 to 2");

    // ------------------------------------------------------------------
    // Effective enables and resets
    // ------------------------------------------------------------------
    logic a_ce, b_ce, in_rstn, pipe_ce, pipe_rstn, load_in;

    assign a_ce      = HIDE_IN_CTRL   ? 1'b1 : i_ctrl.a_ce;
    assign b_ce      = HIDE_IN_CTRL   ? 1'b1 : i_ctrl.b_ce;
    assign in_rstn   = HIDE_IN_CTRL   ? 1'b1 : i_ctrl.in_rstn;
    assign pipe_ce   = HIDE_PIPE_CTRL ? 1'b1 : i_ctrl.pipe_ce;
    assign pipe_rstn = HIDE_PIPE_CTRL ? 1'b1 : i_ctrl.pipe_rstn;
    assign load_in   = ACCUM_EN ? i_ctrl.load : 1'b0;

    // ------------------------------------------------------------------
    // Input registers
    // ------------------------------------------------------------------
    logic [DW-1:0] a_q, a_d, b_q, b_d, a_use, b_use;
    logic          ld_in_q, ld_in_d, ld_use;

    // operand capture with own enables, shared reset
    always_comb begin
        a_d     = a_q;
        b_d     = b_q;
        ld_in_d = ld_in_q;
        if (!in_rstn) begin
            a_d     = '0;
            b_d     = '0;
            ld_in_d = PSOP_RST_VAL;
        end else begin
            if (a_ce) begin
                a_d     = i_din_a;
                // load follows the A operand timing
                ld_in_d = load_in;
            end
            if (b_ce) begin
                b_d = i_din_b;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            a_q     <= '0;
            b_q     <= '0;
            ld_in_q <= PSOP_RST_VAL;
        end else begin
            a_q     <= a_d;
            b_q     <= b_d;
            ld_in_q <= ld_in_d;
        end
    end

    assign a_use  = INPUT_REGS ? a_q : i_din_a;
    assign b_use  = INPUT_REGS ? b_q : i_din_b;
    assign ld_use = INPUT_REGS ? ld_in_q : load_in;

    if (INPUT_REGS) begin : g_in_chk
        // held reset empties the operand registers
        AST_IN_RST: assert property (!in_rstn |=> a_q == '0 && b_q == '0 && !ld_in_q)
            else $error("input registers not cleared by their reset");
        AST_IN_HOLD: assert property (in_rstn && !b_ce |=> $stable(b_q))
            else $error("B operand register changed with its enable low");
    end

    // ------------------------------------------------------------------
    // Multiplier lanes and adder tree
    // ------------------------------------------------------------------
    psop_word_t prod [NUM_MULT];
    psop_word_t sum;

    // lane i takes slice i of each packed vector
    for (genvar i = 0; i < NUM_MULT; i++) begin : g_lane
        psop_lane #(
            .IN_WIDTH   (IN_WIDTH),
            .OUT_WIDTH  (OUT_WIDTH),
            .A_UNSIGNED (A_UNSIGNED),
            .B_UNSIGNED (B_UNSIGNED)
        ) u_lane (
            .i_a    (a_use[i*IN_WIDTH +: IN_WIDTH]),
            .i_b    (b_use[i*IN_WIDTH +: IN_WIDTH]),
            .o_prod (prod[i])
        );
    end

    // all products summed; sum wraps at output width
    always_comb begin
        sum = '0;
        for (int i = 0; i < NUM_MULT; i++) begin
            sum = sum + prod[i];
        end
    end

    // ------------------------------------------------------------------
    // Pipeline stages
    // ------------------------------------------------------------------
    psop_word_t psum_q [PD];
    psop_word_t psum_d [PD];
    logic       pld_q  [PD];
    logic       pld_d  [PD];
    psop_word_t tail;
    logic       ld_tail;

    // stage shift under the shared pipeline enable
    always_comb begin
        for (int k = 0; k < PD; k++) begin
            psum_d[k] = psum_q[k];
            pld_d[k]  = pld_q[k];
            if (!pipe_rstn) begin
                psum_d[k] = '0;
                pld_d[k]  = PSOP_RST_VAL;
            end else if (pipe_ce) begin
                psum_d[k] = (k == 0) ? sum : psum_q[(k == 0) ? 0 : k - 1];
                pld_d[k]  = (k == 0) ? ld_use : pld_q[(k == 0) ? 0 : k - 1];
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        for (int k = 0; k < PD; k++) begin
            if (i_sys_rst) begin
                psum_q[k] <= '0;
                pld_q[k]  <= PSOP_RST_VAL;
            end else begin
                psum_q[k] <= psum_d[k];
                pld_q[k]  <= pld_d[k];
            end
        end
    end

    if (PIPE_STAGES > 0) begin : g_pipe_out
        assign tail    = psum_q[PIPE_STAGES-1];
        assign ld_tail = pld_q[PIPE_STAGES-1];
        // held pipeline reset clears the last stage
        AST_PIPE_RST: assert property (!pipe_rstn |=> tail == '0 && !ld_tail)
            else $error("pipeline stage not cleared by its reset");
        // first stage follows the sum one cycle later when enabled
        AST_PIPE_STEP: assert property (pipe_rstn && pipe_ce |=> psum_q[0] == $past(sum))
            else $error("pipeline stage did not capture the sum");
    end else begin : g_pipe_none
        assign tail    = sum;
        assign ld_tail = ld_use;
    end

    // ------------------------------------------------------------------
    // Output register and accumulator
    // ------------------------------------------------------------------
    psop_word_t acc_q, acc_d;

    // running total; load restarts from the current sum
    always_comb begin
        if (ACCUM_EN && !ld_tail) begin
            acc_d = acc_q + tail;
        end else begin
            acc_d = tail;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign o_dout = acc_q;

    if (ACCUM_EN) begin : g_acc_chk
        // totals carry from cycle to cycle
        AST_ACC_RUN: assert property (!ld_tail |=> acc_q == psop_word_t'($past(acc_q) + $past(tail)))
            else $error("accumulator did not add the sum to its total");
        AST_ACC_LOAD: assert property (ld_tail |=> acc_q == $past(tail))
            else $error("accumulator load did not restart from the sum");
    end else begin : g_noacc_chk
        // without accumulation the output is the sum alone
        AST_NOACC: assert property (1'b1 |=> o_dout == $past(tail))
            else $error("output does not show the current sum");
    end

endmodule : psop_top

/* tb/psop_feed.sv */
// Fabric-side source model: packs per-lane operands into the datapath vectors
`timescale 1ns/1ps
module psop_feed
    import psop_pkg::*;
#(
    parameter int IW = 8,
    parameter int NM = 4
) (
    input  wire logic [IW-1:0]    i_lane_a [NM],
    input  wire logic [IW-1:0]    i_lane_b [NM],
    output logic      [IW*NM-1:0] o_din_a,
    output logic      [IW*NM-1:0] o_din_b
);
    // ------------------------------------------------------------------
    // Lane packing
    // ------------------------------------------------------------------
    // lane i slice
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            o_din_a[i*IW +: IW] = i_lane_a[i];
            o_din_b[i*IW +: IW] = i_lane_b[i];
        end
    end
endmodule : psop_feed

/* tb/psop_bench.sv */
// Bench: random operands and controls checked against a cycle model every clock
`timescale 1ns/1ps
module psop_bench
    import psop_pkg::*;
;
    localparam int IW = 8;
    localparam int NM = 4;
    localparam int OW = 12;
    logic                 i_core_clk;
    logic                 i_sys_rst;
    logic [IW-1:0]        lane_a [NM];
    logic [IW-1:0]        lane_b [NM];
    logic [IW*NM-1:0]     din_a;
    logic [IW*NM-1:0]     din_b;
    psop_ctrl_t           ctrl;
    logic [OW-1:0]        dout;
    logic [47:0]          dout2;
    int                   errors;
    int                   checks;
    logic [15:0]          rnd;
    logic signed [IW-1:0] ma [NM];
    logic signed [IW-1:0] mb [NM];
    logic                 ml;
    logic                 mpl;
    logic [OW-1:0]        mp;
    logic [OW-1:0]        macc;
    logic [47:0]          e2q;
    logic [47:0]          dout3;
    logic [47:0]          e3q;
    logic [47:0]          dly [$];

    // ------------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------------
    psop_feed #(.IW(IW), .NM(NM)) psop_feed_i (
        .i_lane_a (lane_a),
        .i_lane_b (lane_b),
        .o_din_a  (din_a),
        .o_din_b  (din_b)
    );
    // Narrow output on purpose so wraparound is exercised
    psop_top #(.IN_WIDTH(IW), .NUM_MULT(NM), .OUT_WIDTH(OW), .INPUT_REGS(1'b1), .PIPE_STAGES(1),
               .ACCUM_EN(1'b1)) psop_top_i (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_din_a    (din_a),
        .i_din_b    (din_b),
        .i_ctrl     (ctrl),
        .o_dout     (dout)
    );
    // full-width output leaves room for all product growth
    // Mixed signedness, no registers: one cycle through the output register
    psop_top #(.IN_WIDTH(IW), .NUM_MULT(NM), .A_UNSIGNED(1'b1)) psop_top_i2 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_din_a    (din_a),
        .i_din_b    (din_b),
        .i_ctrl     (ctrl),
        .o_dout     (dout2)
    );
    // hidden controls must ignore the random enables and clears
    psop_top #(.IN_WIDTH(IW), .NUM_MULT(NM), .B_UNSIGNED(1'b1), .INPUT_REGS(1'b1), .HIDE_IN_CTRL(1'b1),
               .PIPE_STAGES(2), .HIDE_PIPE_CTRL(1'b1)) psop_top_i3 (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .i_din_a    (din_a),
        .i_din_b    (din_b),
        .i_ctrl     (ctrl),
        .o_dout     (dout3)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic close_out();
        if (errors == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    // Register-level model: accumulator first so it sees the old stage values
    task automatic model_edge();
        longint t;
        longint s;
        int     u;
        t = 0;
        s = 0;
        u = 0;
        for (int i = 0; i < NM; i++) begin
            t += longint'(lane_a[i]) * longint'($signed(lane_b[i]));
            s += longint'($signed(lane_a[i])) * longint'(lane_b[i]);
            u += int'(ma[i]) * int'(mb[i]);
        end
        e2q = i_sys_rst ? 48'h0 : t[47:0];
        // Three register stages ahead of the output register in the deep instance
        if (i_sys_rst) begin
            e3q = 48'h0;
            dly = '{48'h0, 48'h0, 48'h0};
        end else begin
            e3q = dly.pop_back();
            dly.push_front(s[47:0]);
        end
        if (i_sys_rst) begin
            macc = '0;
            mp = '0;
            mpl = 1'b0;
            ml = 1'b0;
            for (int i = 0; i < NM; i++) begin
                ma[i] = '0;
                mb[i] = '0;
            end
        end else begin
            macc = mpl ? mp : macc + mp;
            if (!ctrl.pipe_rstn) begin
                mp = '0;
                mpl = 1'b0;
            end else if (ctrl.pipe_ce) begin
                mp = u[OW-1:0];
                mpl = ml;
            end
            for (int i = 0; i < NM; i++) begin
                if (!ctrl.in_rstn || ctrl.a_ce) ma[i] = ctrl.in_rstn ? lane_a[i] : '0;
                if (!ctrl.in_rstn || ctrl.b_ce) mb[i] = ctrl.in_rstn ? lane_b[i] : '0;
            end
            if (!ctrl.in_rstn || ctrl.a_ce) ml = ctrl.in_rstn & ctrl.load;
        end
    endtask : model_edge

    // Phases: loads with enables high, then random enables and local clears, then a mid-run reset
    task automatic drive(input int c);
        logic quiet;
        quiet = (c < 60 || c >= 125);
        for (int i = 0; i < NM; i++) begin
            rnd = lfsr(rnd);
            lane_a[i] = (c % 16 == 3) ? 8'h80 : rnd[7:0];
            lane_b[i] = (c % 16 == 3) ? 8'h80 : rnd[15:8];
        end
        rnd = lfsr(rnd);
        ctrl.load = quiet ? (c == 0 || rnd[1:0] == 2'h0) : 1'b0;
        ctrl.a_ce = quiet | rnd[2];
        ctrl.b_ce = quiet | rnd[3];
        ctrl.pipe_ce = quiet | rnd[4];
        ctrl.in_rstn = (c >= 70 && c < 120) ? (rnd[7:5] != 3'h0) : 1'b1;
        ctrl.pipe_rstn = (c >= 70 && c < 120) ? (rnd[10:8] != 3'h0) : 1'b1;
        i_sys_rst = (c == 120);
    endtask : drive

    // ------------------------------------------------------------------
    // Clock, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end

    initial begin
        errors = 0;
        checks = 0;
        rnd = 16'h15E4;
        i_sys_rst = 1'b1;
        ctrl = '0;
        ml = 1'b0;
        for (int i = 0; i < NM; i++) begin
            lane_a[i] = '0;
            lane_b[i] = '0;
        end
        // Model runs through reset too so it starts from the cleared state
        repeat (2) begin
            @(posedge i_core_clk);
            model_edge();
        end
        #1 drive(0);
        for (int c = 1; c < 170; c++) begin
            @(posedge i_core_clk);
            model_edge();
            #1;
            check("dout", {36'h0, dout}, {36'h0, macc});
            check("dout_mixed", dout2, e2q);
            check("dout_deep", dout3, e3q);
            drive(c);
        end
        close_out();
    end

    initial begin
        #20000;
        errors++;
        close_out();
    end
endmodule : psop_bench
